//--- shared/wwr_pkg.sv
// What this block does
// [R1] in sleep or idle, wake on port a fall, interrupt, or watchdog overflow
// [R2] halt enters sleep or idle and sets the power-down flag
// [R3] power-down flag cleared by power-up and by the watchdog-clear instruction
// [R4] timeout while halted wakes, sets timeout flag, resets only pc and stack
// [R5] each port a pin has a wake enable; wake resumes after halt
// [R6] wake by disabled or stack-full interrupt resumes after halt, stays pending
// [R7] interrupt already requested at halt is not a wake source
// [R8] watchdog counts low-speed clock; select picks 2^8..2^18 periods
// [R9] enable key 01010 or 10101 enables; other values reset after delay, set flag
// [R10] watchdog key reset flag set by key reset, cleared only by software zero
// [R11] overflow in fast or slow mode gives full reset and sets timeout flag
// [R12] counter cleared by key violation write, clear instruction or halt
// [R13] after power-on the enable key is 01010 and select is 011
// [R14] reset key 01010101 or 10101010 is inert; others reset after delay
// [R15] reset key powers up as 01010101
// [R16] power-on sets pc zero and port data and direction high
// [R17] control reset flag set by reset key violation, cleared only by software
// [R18] software reset delay is a parameter counted in low-speed cycles
package wwr_pkg;
  localparam logic [7:0] WWR_OFF_WDTCTL = 8'h00;
  localparam logic [7:0] WWR_OFF_RSTFLG = 8'h04;
  localparam logic [7:0] WWR_OFF_RSTKEY = 8'h08;
  localparam logic [7:0] WWR_OFF_PAWAKE = 8'h0C;
  localparam logic [7:0] WWR_OFF_STATUS = 8'h10;
  localparam logic [7:0] WWR_OFF_IRQ_ST = 8'h14;
  localparam logic [7:0] WWR_OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] WWR_OFF_IRQ_CLR = 8'h1C;
  localparam logic [7:0] WWR_WDTCTL_RST = 8'h53;
  localparam logic [7:0] WWR_RSTKEY_RST = 8'h55;
  localparam logic [4:0] WWR_WKEY_A = 5'h0A;
  localparam logic [4:0] WWR_WKEY_B = 5'h15;
  localparam logic [7:0] WWR_RKEY_A = 8'h55;
  localparam logic [7:0] WWR_RKEY_B = 8'hAA;
  localparam int WWR_RSTFLG_WKEY = 0;
  localparam int WWR_RSTFLG_CTL = 3;
  localparam int WWR_IRQ_BITS = 3;
  localparam int WWR_IRQ_WDT = 0;
  localparam int WWR_IRQ_WKEY = 1;
  localparam int WWR_IRQ_RKEY = 2;
  localparam int WWR_SRST_DLY = 4;
  localparam int WWR_CNT_W = 18;
  localparam int WWR_LS_DIV = 8;
  localparam logic [7:0] WWR_PORT_RST = 8'hFF;
  typedef enum logic [1:0] {WWR_RUN, WWR_HALTED, WWR_RESET_PEND} wwr_mode_t;
endpackage

//--- design/wwr_wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
// watchdog count on low-speed tick, overflow pulse at selected length
module wwr_wdt_counter
  import wwr_pkg::*;
#(
  parameter int CNT_W = WWR_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic clear,
  input wire logic [2:0] sel,
  output logic overflow
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  // 2^8,2^10,2^12,2^14,2^15..2^18 periods
  always_comb begin
    case (sel)
      3'h0: last = CNT_W'((1 << 8) - 1);
      3'h1: last = CNT_W'((1 << 10) - 1);
      3'h2: last = CNT_W'((1 << 12) - 1);
      3'h3: last = CNT_W'((1 << 14) - 1);
      3'h4: last = CNT_W'((1 << 15) - 1);
      3'h5: last = CNT_W'((1 << 16) - 1);
      3'h6: last = CNT_W'((1 << 17) - 1);
      default: last = CNT_W'((1 << 18) - 1);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear || !enable) begin
        cnt_q <= '0; // [R12]
      end else if (tick) begin
        if (cnt_q >= last) begin
          cnt_q <= '0;
          overflow <= 1'b1; // [R8]
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  chk_clear_empties: assert property (@(posedge pclk) disable iff (!presetn)
      clear |=> cnt_q == '0) // [R12]
    else $error("counter not cleared");
endmodule
`default_nettype wire

//--- design/wwr_top.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wwr_top
  import wwr_pkg::*;
#(
  parameter int PA_W = 8,
  parameter int INT_W = 4,
  parameter int LS_DIV = WWR_LS_DIV,
  parameter int SRST_DLY = WWR_SRST_DLY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic wdt_clear_exec,
  input wire logic [PA_W-1:0] port_a_in,
  input wire logic [INT_W-1:0] int_req,
  input wire logic [INT_W-1:0] int_enable,
  input wire logic stack_full,
  output logic halted,
  output logic wake,
  output logic wake_take_int,
  output logic full_reset,
  output logic pc_sp_reset,
  output logic [PA_W-1:0] port_data_init,
  output logic [PA_W-1:0] port_dir_init,
  output logic irq
);
  // =========================================
  // register bus
  logic [7:0] wdt_ctl_q;
  logic [7:0] rst_key_q;
  logic [7:0] pa_wake_mask_q;
  logic wkey_flag_q;
  logic ctl_flag_q;
  logic pwrdn_q;
  logic tof_q;
  logic [WWR_IRQ_BITS-1:0] irq_st_q;
  logic [WWR_IRQ_BITS-1:0] irq_en_q;
  wwr_mode_t mode_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic wkey_bad;
  logic rkey_bad;
  logic wkey_viol_wr;
  logic ls_tick;
  logic wdt_ovf;
  logic pend_q;
  logic pend_wkey_q;
  logic [15:0] dly_q;
  logic [15:0] lsdiv_q;
  logic [PA_W-1:0] pa_prev_q;
  logic [INT_W-1:0] int_armed_q;
  logic pa_fall;
  logic int_wake;
  logic [31:0] rdata;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr <= WWR_OFF_IRQ_CLR) && (paddr[1:0] == 2'h0);
  assign wkey_bad = (wdt_ctl_q[7:3] != WWR_WKEY_A) && (wdt_ctl_q[7:3] != WWR_WKEY_B);
  assign rkey_bad = (rst_key_q != WWR_RKEY_A) && (rst_key_q != WWR_RKEY_B);
  assign wkey_viol_wr = wr_en && paddr == WWR_OFF_WDTCTL
      && pwdata[7:3] != WWR_WKEY_A && pwdata[7:3] != WWR_WKEY_B;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_ctl_q <= WWR_WDTCTL_RST; // [R13]
      rst_key_q <= WWR_RSTKEY_RST; // [R15]
      pa_wake_mask_q <= 8'h00;
      irq_en_q <= '0;
    end else if (full_reset) begin
      wdt_ctl_q <= WWR_WDTCTL_RST;
      rst_key_q <= WWR_RSTKEY_RST;
      pa_wake_mask_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        WWR_OFF_WDTCTL: wdt_ctl_q <= pwdata[7:0];
        WWR_OFF_RSTKEY: rst_key_q <= pwdata[7:0];
        WWR_OFF_PAWAKE: pa_wake_mask_q <= pwdata[7:0]; // [R5]
        WWR_OFF_IRQ_EN: irq_en_q <= pwdata[WWR_IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      WWR_OFF_WDTCTL: rdata[7:0] = wdt_ctl_q;
      WWR_OFF_RSTFLG: rdata[7:0] = {4'h0, ctl_flag_q, 2'h0, wkey_flag_q};
      WWR_OFF_RSTKEY: rdata[7:0] = rst_key_q;
      WWR_OFF_PAWAKE: rdata[7:0] = pa_wake_mask_q;
      WWR_OFF_STATUS: rdata[7:0] = {6'h00, tof_q, pwrdn_q};
      WWR_OFF_IRQ_ST: rdata[WWR_IRQ_BITS-1:0] = irq_st_q;
      WWR_OFF_IRQ_EN: rdata[WWR_IRQ_BITS-1:0] = irq_en_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata : prdata;
    end
  end

  // =========================================
  // low-speed tick and watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsdiv_q <= '0;
      ls_tick <= 1'b0;
    end else begin
      ls_tick <= (lsdiv_q == 16'(LS_DIV - 1));
      lsdiv_q <= (lsdiv_q == 16'(LS_DIV - 1)) ? 16'h0000 : lsdiv_q + 16'h0001;
    end
  end

  wwr_wdt_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(ls_tick),
    .enable(!wkey_bad), // [R9]
    .clear(wkey_viol_wr || wdt_clear_exec || halt_exec || full_reset), // [R12]
    .sel(wdt_ctl_q[2:0]), // [R8]
    .overflow(wdt_ovf)
  );

  // =========================================
  // wake sources
  assign pa_fall = |(pa_prev_q & ~port_a_in & pa_wake_mask_q[PA_W-1:0]); // [R5]
  assign int_wake = |(int_req & int_armed_q); // [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_prev_q <= '0;
      int_armed_q <= '0;
    end else begin
      pa_prev_q <= port_a_in;
      if (halt_exec && mode_q == WWR_RUN) begin
        int_armed_q <= ~int_req; // [R7]
      end
    end
  end

  // =========================================
  // mode and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= WWR_RUN;
      halted <= 1'b0;
      wake <= 1'b0;
      wake_take_int <= 1'b0;
      pc_sp_reset <= 1'b0;
      pwrdn_q <= 1'b0; // [R3]
      tof_q <= 1'b0;
    end else begin
      wake <= 1'b0;
      wake_take_int <= 1'b0;
      pc_sp_reset <= 1'b0;
      if (wdt_clear_exec) begin
        pwrdn_q <= 1'b0; // [R3]
      end
      case (mode_q)
        WWR_RUN: begin
          if (wdt_ovf) begin
            tof_q <= 1'b1; // [R11]
          end else if (halt_exec) begin
            mode_q <= WWR_HALTED;
            halted <= 1'b1;
            pwrdn_q <= 1'b1; // [R2]
            tof_q <= 1'b0;
          end
        end
        WWR_HALTED: begin
          if (wdt_ovf || pa_fall || int_wake) begin // [R1]
            mode_q <= WWR_RUN;
            halted <= 1'b0;
            wake <= 1'b1;
            pc_sp_reset <= wdt_ovf; // [R4]
            tof_q <= tof_q | wdt_ovf; // [R4]
            // serviced only if enabled with stack room, else stays pending
            wake_take_int <= !wdt_ovf && |(int_req & int_armed_q & int_enable)
                && !stack_full; // [R6]
          end
        end
        default: mode_q <= WWR_RUN;
      endcase
    end
  end

  // =========================================
  // key violation reset delay and run-mode overflow reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pend_wkey_q <= 1'b0;
      dly_q <= '0;
      full_reset <= 1'b0;
    end else begin
      full_reset <= 1'b0;
      if (full_reset) begin
        pend_q <= 1'b0;
      end else if (pend_q) begin
        if (ls_tick) begin
          dly_q <= dly_q + 16'h0001;
        end
        if (dly_q >= 16'(SRST_DLY)) begin // [R18]
          full_reset <= 1'b1; // [R9] [R14]
        end
      end else if (wkey_bad || rkey_bad) begin
        pend_q <= 1'b1;
        pend_wkey_q <= wkey_bad;
        dly_q <= '0;
      end else if (wdt_ovf && mode_q == WWR_RUN) begin
        full_reset <= 1'b1; // [R11]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wkey_flag_q <= 1'b0;
      ctl_flag_q <= 1'b0;
    end else begin
      if (full_reset && pend_q && pend_wkey_q) begin
        wkey_flag_q <= 1'b1; // [R10]
      end else if (wr_en && paddr == WWR_OFF_RSTFLG && !pwdata[WWR_RSTFLG_WKEY]) begin
        wkey_flag_q <= 1'b0; // [R10]
      end
      if (full_reset && pend_q && !pend_wkey_q) begin
        ctl_flag_q <= 1'b1; // [R17]
      end else if (wr_en && paddr == WWR_OFF_RSTFLG && !pwdata[WWR_RSTFLG_CTL]) begin
        ctl_flag_q <= 1'b0; // [R17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_init <= '1; // [R16]
      port_dir_init <= '1; // [R16]
    end else begin
      port_data_init <= full_reset ? '1 : port_data_init;
      port_dir_init <= full_reset ? '1 : port_dir_init;
    end
  end

  // =========================================
  // interrupts: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_en && paddr == WWR_OFF_IRQ_CLR)
          ? pwdata[WWR_IRQ_BITS-1:0] : '0))
          | {full_reset && pend_q && !pend_wkey_q, full_reset && pend_q && pend_wkey_q,
             wdt_ovf};
      irq <= |(irq_st_q & irq_en_q);
    end
  end

  chk_halt_sets_pdown: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == WWR_RUN && halt_exec && !wdt_ovf) |=> pwrdn_q && halted) // [R2]
    else $error("halt did not set power-down");
  chk_clr_pdown: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_clear_exec |=> !pwrdn_q) // [R3]
    else $error("clear did not drop power-down");
  chk_ovf_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == WWR_HALTED && wdt_ovf) |=> wake && pc_sp_reset && tof_q) // [R4]
    else $error("overflow wake wrong");
  chk_pa_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == WWR_HALTED && pa_fall) |=> wake && !halted) // [R1]
    else $error("port wake missed");
  chk_armed_only: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == WWR_HALTED && !wdt_ovf && !pa_fall && !int_wake) |=> !wake) // [R7]
    else $error("spurious wake");
  chk_run_ovf_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == WWR_RUN && wdt_ovf && !pend_q && !wkey_bad && !rkey_bad)
      |=> full_reset && tof_q) // [R11]
    else $error("overflow did not reset");
  chk_key_delay: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(pend_q)) |-> !full_reset [*2]) // [R18]
    else $error("reset came with no delay");
  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (wkey_flag_q && !(wr_en && paddr == WWR_OFF_RSTFLG)) |=> wkey_flag_q) // [R10]
    else $error("key flag cleared by hardware");
  chk_rkey_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (full_reset) |=> rst_key_q == WWR_RSTKEY_RST) // [R14]
    else $error("key not restored");
  cov_halt_wake: cover property (@(posedge pclk) disable iff (!presetn)
      halted ##[1:200] wake);
  cov_key_reset: cover property (@(posedge pclk) disable iff (!presetn)
      pend_q ##[1:1000] full_reset);
  cov_int_take: cover property (@(posedge pclk) disable iff (!presetn) wake_take_int);
endmodule
`default_nettype wire

//--- verif/wwr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// core side: issues halt and clear instructions
module wwr_core_model (
  input wire logic pclk,
  input wire logic halted,
  output logic halt_exec,
  output logic wdt_clear_exec
);
  initial begin
    halt_exec = 1'b0;
    wdt_clear_exec = 1'b0;
  end
  // a halted core executes nothing
  task automatic do_halt();
    @(posedge pclk);
    if (halted !== 1'b1) halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
  endtask
  task automatic do_clear();
    @(posedge pclk);
    if (halted !== 1'b1) wdt_clear_exec <= 1'b1;
    @(posedge pclk);
    wdt_clear_exec <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wwr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, halt_exec, wdt_clear_exec, stack_full = 1'b0, err;
  logic [7:0] port_a_in = 8'hFF, pdi, pdr;
  logic [3:0] int_req = 4'h0, int_enable = 4'h0;
  logic halted, wake, wake_take_int, full_reset, pc_sp_reset, irq, last_take;
  int n_fail = 0, cmp_count = 0, nwk = 0, nfr = 0, npc = 0;
  always #2 pclk = ~pclk;
  wwr_top #(.LS_DIV(8), .SRST_DLY(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
    .wdt_clear_exec(wdt_clear_exec), .port_a_in(port_a_in), .int_req(int_req),
    .int_enable(int_enable), .stack_full(stack_full), .halted(halted), .wake(wake),
    .wake_take_int(wake_take_int), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset),
    .port_data_init(pdi), .port_dir_init(pdr), .irq(irq));
  wwr_core_model core_u (.pclk(pclk), .halted(halted), .halt_exec(halt_exec),
    .wdt_clear_exec(wdt_clear_exec));
  // ==========================================
  // event counters, pulses sampled mid-cycle
  always @(negedge pclk) begin
    if (wake === 1'b1) begin
      nwk++;
      last_take = wake_take_int;
    end
    if (full_reset === 1'b1) nfr++;
    if (pc_sp_reset === 1'b1) npc++;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================
  // apb transfer, released only after pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic int cnt(input int w);
    if (w == 0) return nwk;
    if (w == 1) return nfr;
    return npc;
  endfunction
  // wait for an event counter to move, or check that it stays
  task automatic wait_ev(input int w, input int maxc, input logic exp);
    int c0, i;
    c0 = cnt(w);
    for (i = 0; i < maxc && cnt(w) == c0; i++) @(posedge pclk);
    chk({31'h0, cnt(w) != c0}, {31'h0, exp});
    if (exp && cnt(w) == c0) stop_test();
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({24'h0, pdi}, {24'h0, WWR_PORT_RST});
    chk({24'h0, pdr}, {24'h0, WWR_PORT_RST});
    rchk(WWR_OFF_WDTCTL, 32'h0000_0053);
    rchk(WWR_OFF_RSTKEY, 32'h0000_0055);
    rchk(WWR_OFF_RSTFLG, 32'h0000_0000);
    rchk(WWR_OFF_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    tdone("reset");
    apb(1'b1, WWR_OFF_PAWAKE, 32'h0000_0001);
    core_u.do_halt();
    rchk(WWR_OFF_STATUS, 32'h0000_0001);
    port_a_in <= 8'hFD;
    wait_ev(0, 20, 1'b0);
    port_a_in <= 8'hFC;
    wait_ev(0, 20, 1'b1);
    chk({31'h0, last_take}, 32'h0);
    port_a_in <= 8'hFF;
    core_u.do_clear();
    rchk(WWR_OFF_STATUS, 32'h0000_0000);
    tdone("port wake");
    int_req <= 4'h1;
    core_u.do_halt();
    wait_ev(0, 30, 1'b0);
    port_a_in <= 8'hFE;
    wait_ev(0, 20, 1'b1);
    port_a_in <= 8'hFF;
    for (int i = 1; i < 4; i++) begin
      int_enable <= (i > 1) ? 4'hE : 4'h0;
      stack_full <= (i == 2);
      core_u.do_halt();
      int_req[i] <= 1'b1;
      wait_ev(0, 20, 1'b1);
      chk({31'h0, last_take}, {31'h0, i == 3});
    end
    int_req <= 4'h0;
    int_enable <= 4'h0;
    tdone("interrupt wake");
    apb(1'b1, WWR_OFF_WDTCTL, 32'h0000_0050);
    apb(1'b1, WWR_OFF_IRQ_EN, 32'h0000_0001);
    core_u.do_halt();
    wait_ev(2, 2300, 1'b1);
    chk({31'h0, halted}, 32'h0);
    chk(nfr, 0);
    rchk(WWR_OFF_STATUS, 32'h0000_0003);
    core_u.do_clear();
    repeat (1500) @(posedge pclk);
    core_u.do_clear();
    wait_ev(1, 1500, 1'b0);
    wait_ev(1, 800, 1'b1);
    rchk(WWR_OFF_STATUS, 32'h0000_0002);
    rchk(WWR_OFF_IRQ_ST, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, WWR_OFF_IRQ_EN, 32'h0000_0000);
    // irq is registered from the enable, so it falls one edge after the write
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, WWR_OFF_IRQ_CLR, 32'h0000_0001);
    rchk(WWR_OFF_IRQ_ST, 32'h0000_0000);
    apb(1'b1, WWR_OFF_WDTCTL, 32'h0000_0053);
    tdone("overflow");
    apb(1'b1, WWR_OFF_WDTCTL, 32'h0000_00A8);
    wait_ev(1, 100, 1'b0);
    apb(1'b1, WWR_OFF_WDTCTL, 32'h0000_0003);
    wait_ev(1, 20, 1'b0);
    wait_ev(1, 40, 1'b1);
    rchk(WWR_OFF_RSTFLG, 32'h0000_0001);
    rchk(WWR_OFF_WDTCTL, 32'h0000_0053);
    apb(1'b1, WWR_OFF_RSTFLG, 32'h0000_0000);
    rchk(WWR_OFF_RSTFLG, 32'h0000_0000);
    apb(1'b1, WWR_OFF_RSTKEY, 32'h0000_00AA);
    wait_ev(1, 100, 1'b0);
    apb(1'b1, WWR_OFF_RSTKEY, 32'h0000_0012);
    wait_ev(1, 20, 1'b0);
    wait_ev(1, 40, 1'b1);
    rchk(WWR_OFF_RSTFLG, 32'h0000_0008);
    rchk(WWR_OFF_RSTKEY, 32'h0000_0055);
    apb(1'b1, WWR_OFF_RSTFLG, 32'h0000_0000);
    rchk(WWR_OFF_RSTFLG, 32'h0000_0000);
    tdone("key reset");
    stop_test();
  end
endmodule
`default_nettype wire
